// file: lphy_top.sv
// LIN physical layer digital side: transmit mapping, receive mirror,
// permanent dominant timeout and low-power bus wake filtering.
// Assumes the analogue driver and comparator sit outside, mode comes from
// the mode controller, and all inputs are synchronous to mclk.
// Notes on behaviour
// RL1: Receive output low when bus dominant.
// RL2: Transmit low drives bus dominant, high recessive.
// RL3: Undriven transmit input reads high, bus recessive.
// RL4: Transceiver active only in Normal modes.
// RL5: Low-power wake passes a deglitch filter first.
// RL6: Stop-mode bus wake pulls interrupt low.
// RL7: Transmit held dominant about 1 s: timeout.
// RL8: Stop wake interrupt between 9 and 17 us.
`timescale 1ns/1ps
`include "lphy_consts.svh"

module lphy_top
#(
  parameter int unsigned DOM_LIMIT_CYC = `LPHY_DOM_LIMIT_CYC
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Operating mode
  input  wire lphy_pkg::lphy_mode_type mode,
  // Controller side
  input  wire logic             txd_in,
  input  wire logic             txd_driven,
  output logic                  rxd_out,
  output logic                  irq_n,
  input  wire logic             irq_ack,
  // Bus side
  input  wire logic             bus_dominant,
  output logic                  bus_drive_dom,
  output logic                  tx_dom_timeout,
  output logic                  wake_event
);
  import lphy_pkg::*;

  // Transceiver and low-power decode
  logic          active;
  logic          low_power;
  logic          in_stop;
  logic          txd_eff;
  // Permanent dominant timer
  logic [31:0]   dom_cnt_q;
  logic          dom_at_limit;
  logic          timeout_q;
  // Bus drive and receive mirror
  logic          drive_d;
  logic          drive_q;
  logic          rxd_d;
  logic          rxd_q;
  // Wake filter and report
  lphy_wake_type wk_q;
  logic [15:0]   wk_cnt_q;
  logic          wk_filt_end;
  logic          wk_rep_end;
  logic          wake_q;
  // Interrupt
  logic          irq_set;
  logic          irq_q;

  assign active    = (mode == LPHY_MODE_NORMAL) ||
                     (mode == LPHY_MODE_NORMAL_REQ);           // RL4
  assign low_power = (mode == LPHY_MODE_SLEEP) ||
                     (mode == LPHY_MODE_STOP);
  assign in_stop   = (mode == LPHY_MODE_STOP);
  // Floating input counts as high
  assign txd_eff   = txd_driven ? txd_in : 1'b1;              // RL3

  // Last count before the timeout; drive must already drop here
  assign dom_at_limit = (dom_cnt_q >= DOM_LIMIT_CYC - 1);      // RL7

  // Permanent dominant counter
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      dom_cnt_q <= 32'h0000_0000;
    else if (!active || txd_eff)
      dom_cnt_q <= 32'h0000_0000;
    else if (!dom_at_limit)
      dom_cnt_q <= dom_cnt_q + 32'h0000_0001;
  end

  // Timeout flag, held until the request ends
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      timeout_q <= 1'b0;
    else if (!active || txd_eff)
      timeout_q <= 1'b0;
    else if (dom_at_limit)
      timeout_q <= 1'b1;                                       // RL7
  end

  // Bus drive: dominant on low transmit, released after timeout
  always_comb
  begin
    drive_d = 1'b0;
    if (active && !txd_eff)
      drive_d = !(timeout_q || dom_at_limit);                  // RL2 RL7
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      drive_q <= 1'b0;
    else
      drive_q <= drive_d;                                      // RL2
  end

  // Receive mirror; recessive when transceiver is off
  always_comb
  begin
    rxd_d = 1'b1;
    if (active)
      rxd_d = !bus_dominant;                                   // RL1 RL4
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rxd_q <= 1'b1;
    else
      rxd_q <= rxd_d;                                          // RL1
  end

  // Filter and report end points
  assign wk_filt_end = (wk_cnt_q >= 16'(`LPHY_DEGLITCH_CYC - 2));
  assign wk_rep_end  = (wk_cnt_q >= 16'(`LPHY_WAKE_REPORT_CYC - 1));

  // Wake state: a dominant run must outlast the deglitch time
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wk_q <= LPHY_WK_IDLE;
    else if (!low_power)
      wk_q <= LPHY_WK_IDLE;
    else
    begin
      unique case (wk_q)
        LPHY_WK_IDLE:
        begin
          if (bus_dominant)
            wk_q <= LPHY_WK_FILTER;
        end
        LPHY_WK_FILTER:
        begin
          if (!bus_dominant)
            wk_q <= LPHY_WK_IDLE;                              // RL5
          else if (wk_filt_end)
            wk_q <= LPHY_WK_REPORT;                            // RL5
        end
        LPHY_WK_REPORT:
        begin
          if (wk_rep_end)
            wk_q <= LPHY_WK_DONE;                              // RL8
        end
        LPHY_WK_DONE:
        begin
          // Parked until the low-power stay ends
          wk_q <= LPHY_WK_DONE;
        end
      endcase
    end
  end

  // Shared cycle counter for filter and report phases
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wk_cnt_q <= 16'h0000;
    else if (!low_power)
      wk_cnt_q <= 16'h0000;
    else
    begin
      unique case (wk_q)
        LPHY_WK_IDLE:
          wk_cnt_q <= 16'h0000;
        LPHY_WK_FILTER:
        begin
          if (!bus_dominant)
            wk_cnt_q <= 16'h0000;
          else if (wk_filt_end)
            wk_cnt_q <= 16'h0000;
          else
            wk_cnt_q <= wk_cnt_q + 16'h0001;
        end
        LPHY_WK_REPORT:
        begin
          if (!wk_rep_end)
            wk_cnt_q <= wk_cnt_q + 16'h0001;
        end
        LPHY_WK_DONE:
          wk_cnt_q <= 16'h0000;
      endcase
    end
  end

  // One-cycle pulse when the filter accepts a wake
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wake_q <= 1'b0;
    else
      wake_q <= low_power && (wk_q == LPHY_WK_FILTER) &&
                bus_dominant && wk_filt_end;                   // RL5
  end

  // Interrupt set only for a Stop-mode wake, after the report delay
  assign irq_set = in_stop && (wk_q == LPHY_WK_REPORT) && wk_rep_end;

  // Set wins over a same-cycle acknowledge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else if (irq_set)
      irq_q <= 1'b1;                                           // RL6 RL8
    else if (irq_ack)
      irq_q <= 1'b0;
  end

  assign bus_drive_dom  = drive_q;
  assign rxd_out        = rxd_q;
  assign irq_n          = !irq_q;                              // RL6
  assign tx_dom_timeout = timeout_q;
  assign wake_event     = wake_q;

endmodule // lphy_top

// file: lphy_consts.svh
// Timing constants for the LIN physical layer digital side.
// Assumes a 50 MHz mclk.
`ifndef LPHY_CONSTS_SVH
`define LPHY_CONSTS_SVH

`define LPHY_CLK_MHZ           50
// Permanent dominant limit, in ms (nominal 1000, window 650..1350)
`define LPHY_DOM_LIMIT_MS      1000
`define LPHY_DOM_LIMIT_CYC     (`LPHY_DOM_LIMIT_MS * 1000 * `LPHY_CLK_MHZ)
// Wake deglitch time, in us (least 42)
`define LPHY_DEGLITCH_US       42
`define LPHY_DEGLITCH_CYC      (`LPHY_DEGLITCH_US * `LPHY_CLK_MHZ)
// Wake report delay after deglitch, in us: target 13, within 9.0..17
`define LPHY_WAKE_REPORT_US    13
`define LPHY_WAKE_REPORT_CYC   (`LPHY_WAKE_REPORT_US * `LPHY_CLK_MHZ)

`endif

// file: lphy_pkg.sv
// Types for the LIN physical layer digital side.
// Assumes lphy_consts.svh holds the numbers.
package lphy_pkg;

  typedef enum logic [2:0]
  {
    LPHY_MODE_NORMAL_REQ,
    LPHY_MODE_NORMAL,
    LPHY_MODE_SLEEP,
    LPHY_MODE_STOP,
    LPHY_MODE_RESET
  } lphy_mode_type;

  typedef enum logic [1:0]
  {
    LPHY_WK_IDLE,
    LPHY_WK_FILTER,
    LPHY_WK_REPORT,
    LPHY_WK_DONE
  } lphy_wake_type;

endpackage

// file: lphy_bus_node.sv
// Peer LIN node; dominant wins on the wire.
// Assumes the bench sets peer_dom.
`timescale 1ns/1ps
module lphy_bus_node (input wire logic bus_drive_dom, peer_dom,
  output logic bus_dominant);
  assign bus_dominant = bus_drive_dom | peer_dom;
endmodule // lphy_bus_node

// file: lphy_chk.sv
// Checker for lphy_top ports.
// Assumes bind by port name.
`timescale 1ns/1ps
module lphy_chk import lphy_pkg::*;
#(parameter int unsigned DOM_LIMIT_CYC = 100)
(input wire logic mclk, rst_n, txd_in, txd_driven, irq_ack, bus_dominant,
  input wire lphy_mode_type mode,
  input wire logic rxd_out, irq_n, bus_drive_dom, tx_dom_timeout, wake_event);
  int dom_q, bus_q;
  wire nm = mode < 2;
  always_ff @(posedge mclk)
    dom_q <= nm && txd_driven && !txd_in ? dom_q + 1 : 0;
  // Dominant run length in Sleep or Stop
  always_ff @(posedge mclk)
    bus_q <= bus_dominant && mode[2:1] == 2'h1 ? bus_q + 1 : 0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_rx_mirror: assert property (
    nm |=> rxd_out == !$past(bus_dominant)) else $error("rx");
  chk_tx_high: assert property (
    nm && txd_driven && txd_in |=> !bus_drive_dom) else $error("tx");
  chk_tx_low: assert property (
    nm && txd_driven && $fell(txd_in) |=> bus_drive_dom) else $error("tx");
  chk_tx_open: assert property (
    nm && !txd_driven |=> !bus_drive_dom) else $error("open");
  chk_mode_idle: assert property (
    !nm |=> rxd_out && !bus_drive_dom) else $error("idle");
  chk_dom_limit: assert property (
    dom_q == DOM_LIMIT_CYC + 2 |-> tx_dom_timeout && !bus_drive_dom)
    else $error("dom");
  chk_wake_filter: assert property (
    wake_event |-> $past(bus_q) > 2097) else $error("wake");
  chk_irq_delay: assert property (
    wake_event && mode == 3 |-> ##[450:850] !irq_n) else $error("irq");
  chk_irq_stop_only: assert property (
    $fell(irq_n) |-> $past(mode) == 3) else $error("irq mode");
  chk_irq_held: assert property (
    !irq_n && !irq_ack |=> !irq_n) else $error("irq held");
  cover property (tx_dom_timeout);
  cover property (wake_event);
  cover property ($fell(irq_n));
  cover property ($rose(irq_n));
endmodule // lphy_chk
bind lphy_top lphy_chk #(.DOM_LIMIT_CYC(DOM_LIMIT_CYC)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .txd_in(txd_in), .txd_driven(txd_driven),
  .irq_ack(irq_ack), .bus_dominant(bus_dominant), .mode(mode),
  .rxd_out(rxd_out), .irq_n(irq_n), .bus_drive_dom(bus_drive_dom),
  .tx_dom_timeout(tx_dom_timeout), .wake_event(wake_event));

// file: testbench.sv
// Bench for lphy_top beside a peer node.
// Assumes package, peer and checker compile first.
`timescale 1ns/1ps
`include "lphy_consts.svh"
module testbench;
  logic mclk = 0, rst_n = 0, txd_in = 1, txd_driven = 1, irq_ack = 0;
  logic peer_dom = 0, rxd_out, irq_n, bus_drive_dom, tx_dom_timeout;
  logic wake_event, bus_dominant;
  lphy_pkg::lphy_mode_type mode = lphy_pkg::LPHY_MODE_NORMAL;
  int errors = 0, samples_checked = 0, n;
  lphy_top #(.DOM_LIMIT_CYC(100)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .mode(mode), .txd_in(txd_in),
    .txd_driven(txd_driven), .rxd_out(rxd_out), .irq_n(irq_n),
    .irq_ack(irq_ack), .bus_dominant(bus_dominant),
    .bus_drive_dom(bus_drive_dom), .tx_dom_timeout(tx_dom_timeout),
    .wake_event(wake_event));
  lphy_bus_node peer_u (.bus_drive_dom(bus_drive_dom), .peer_dom(peer_dom),
    .bus_dominant(bus_dominant));
  initial
    forever #10 mclk = ~mclk;
  task print_verdict;
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [11:0] s, e);
    samples_checked++;
    errors += s !== e;
    if (s !== e)
      $display("[ERR] %0t %h %h", $time, s, e);
  endtask
  // Mode code, transmit level, driven, peer pull, then k settled samples
  task go(input int m, input logic t, d, p, input int k);
    @(posedge mclk);
    mode <= lphy_pkg::lphy_mode_type'(m);
    {txd_in, txd_driven, peer_dom} <= {t, d, p};
    repeat (k) @(negedge mclk);
  endtask
  task t_link;
    go(1, 0, 1, 0, 3);
    chk({bus_drive_dom, rxd_out}, 12'h0002);
    go(0, 0, 0, 1, 3);
    chk({bus_drive_dom, rxd_out}, 12'h0000);
  endtask
  task t_timeout;
    go(1, 0, 1, 0, 99);
    chk({tx_dom_timeout, bus_drive_dom}, 12'h0001);
    repeat (5) @(negedge mclk);
    chk({tx_dom_timeout, bus_drive_dom}, 12'h0002);
  endtask
  task t_wake;
    go(3, 1, 1, 1, 1000);
    go(3, 1, 1, 0, 3000);
    chk(irq_n, 12'h0001);
    go(3, 1, 1, 1, 0);
    for (n = 0; irq_n !== 0 && n < 3000; n++)
      @(negedge mclk);
    chk(n inside {[2550:2960]}, 12'h0001);
    @(posedge mclk);
    irq_ack <= 1;
    @(posedge mclk);
    irq_ack <= 0;
    @(negedge mclk);
    chk(irq_n, 12'h0001);
  endtask
  task t_sleep;
    go(0, 1, 1, 0, 2);
    go(2, 1, 1, 1, 0);
    for (n = 0; wake_event !== 1 && n < 3000; n++)
      @(negedge mclk);
    chk(12'(n), 12'(`LPHY_DEGLITCH_CYC + 1));
    repeat (1000) @(negedge mclk);
    chk(irq_n, 12'h0001);
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    t_link;
    t_timeout;
    t_wake;
    t_sleep;
    print_verdict;
  end
  initial
  begin
    repeat (14000) @(posedge mclk);
    errors++;
    print_verdict;
  end
endmodule // testbench
